// File: rtl/fbp_flash_block_protection.sv
`timescale 1ns/100ps
// How it works
// - 64 KB flash, 1 KB blocks erased singly
// - Erased block reads all ones
// - One setting covers each 2 KB pair
// - Pair is open, read-only or execute-only
// - Read-only refuses erase, program; allows reads
// - Execute-only serves instruction fetches only
// - Permitted read data after one cycle
module fbp_flash_block_protection #(
    parameter int NUM_UNITS = fbp_pkg::NUM_UNITS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Instruction fetch port
    input wire logic fetch_req,
    input wire logic [fbp_pkg::WORD_ADDR_W-1:0] fetch_addr,
    output logic fetch_valid,
    output logic [31:0] fetch_data,
    // Processor data read port
    input wire logic data_req,
    input wire logic [fbp_pkg::WORD_ADDR_W-1:0] data_addr,
    output logic data_valid,
    output logic [31:0] data_rdata,
    // Debugger read port
    input wire logic dbg_req,
    input wire logic [fbp_pkg::WORD_ADDR_W-1:0] dbg_addr,
    output logic dbg_valid,
    output logic [31:0] dbg_rdata,
    // Program and erase commands
    input wire logic prog_req,
    input wire logic [fbp_pkg::WORD_ADDR_W-1:0] prog_addr,
    input wire logic [31:0] prog_data,
    input wire logic erase_req,
    input wire logic [fbp_pkg::BLOCK_W-1:0] erase_block,
    output logic busy,
    output logic done,
    // Protection settings
    input wire logic prot_we,
    input wire logic [fbp_pkg::UNIT_W-1:0] prot_unit,
    input wire logic [1:0] prot_value,
    // Violation status
    input wire logic violation_clear,
    output logic violation,
    output logic [fbp_pkg::WORD_ADDR_W-1:0] violation_addr
);
    localparam int DEPTH = fbp_pkg::FLASH_BYTES / fbp_pkg::WORD_BYTES;

    logic [31:0] mem [DEPTH];
    logic [2*NUM_UNITS-1:0] prot_q, prot_d;
    fbp_pkg::fbp_state_type state_q, state_d;
    logic [fbp_pkg::BLOCK_W-1:0] erase_blk_q, erase_blk_d;
    logic [fbp_pkg::BLOCK_WORD_W-1:0] erase_cnt_q, erase_cnt_d;
    logic busy_q, busy_d, done_q, done_d;
    logic viol_q, viol_d;
    logic [fbp_pkg::WORD_ADDR_W-1:0] viol_addr_q, viol_addr_d;
    logic fetch_valid_q, data_valid_q, dbg_valid_q;
    logic [31:0] fetch_data_q, data_rdata_q, dbg_rdata_q;
    logic fetch_ok, data_ok, dbg_ok, prog_ok, erase_ok;
    logic mem_we;
    logic [fbp_pkg::WORD_ADDR_W-1:0] mem_waddr;
    logic [31:0] mem_wdata;

    function automatic logic [fbp_pkg::BLOCK_W-1:0] block_of(
        input logic [fbp_pkg::WORD_ADDR_W-1:0] addr
    );
        block_of = addr[fbp_pkg::WORD_ADDR_W-1:fbp_pkg::BLOCK_WORD_W];
    endfunction

    fbp_prot_check u_fetch_chk (
        .prot_map(prot_q),
        .block_index(block_of(fetch_addr)),
        .is_modify(1'b0),
        .is_data_read(1'b0),
        .allowed(fetch_ok)
    );
    fbp_prot_check u_data_chk (
        .prot_map(prot_q),
        .block_index(block_of(data_addr)),
        .is_modify(1'b0),
        .is_data_read(1'b1),
        .allowed(data_ok)
    );
    fbp_prot_check u_dbg_chk (
        .prot_map(prot_q),
        .block_index(block_of(dbg_addr)),
        .is_modify(1'b0),
        .is_data_read(1'b1),
        .allowed(dbg_ok)
    );
    fbp_prot_check u_prog_chk (
        .prot_map(prot_q),
        .block_index(block_of(prog_addr)),
        .is_modify(1'b1),
        .is_data_read(1'b0),
        .allowed(prog_ok)
    );
    fbp_prot_check u_erase_chk (
        .prot_map(prot_q),
        .block_index(erase_block),
        .is_modify(1'b1),
        .is_data_read(1'b0),
        .allowed(erase_ok)
    );

    // Protection table
    always_comb begin
        prot_d = prot_q;
        if (prot_we) begin
            prot_d[2*prot_unit +: 2] = prot_value;
        end
    end

    // Program and erase sequencing
    always_comb begin
        state_d = state_q;
        erase_blk_d = erase_blk_q;
        erase_cnt_d = erase_cnt_q;
        done_d = 1'b0;
        viol_d = viol_q;
        viol_addr_d = viol_addr_q;
        mem_we = 1'b0;
        mem_waddr = prog_addr;
        mem_wdata = prog_data;
        if (violation_clear) begin
            viol_d = 1'b0;
        end
        unique case (state_q)
            fbp_pkg::FBP_IDLE: begin
                if (erase_req) begin
                    if (erase_ok) begin
                        state_d = fbp_pkg::FBP_ERASE;
                        erase_blk_d = erase_block;
                        erase_cnt_d = '0;
                    end else begin
                        viol_d = 1'b1;
                        viol_addr_d = {erase_block, {fbp_pkg::BLOCK_WORD_W{1'b0}}};
                    end
                end else if (prog_req) begin
                    if (prog_ok) begin
                        // Programming only clears bits, as flash cells do
                        mem_we = 1'b1;
                        mem_wdata = mem[prog_addr] & prog_data;
                        done_d = 1'b1;
                    end else begin
                        viol_d = 1'b1;
                        viol_addr_d = prog_addr;
                    end
                end
            end
            fbp_pkg::FBP_ERASE: begin
                mem_we = 1'b1;
                mem_waddr = {erase_blk_q, erase_cnt_q};
                mem_wdata = fbp_pkg::ERASED_WORD;
                erase_cnt_d = erase_cnt_q + 1'b1;
                if (erase_cnt_q == (fbp_pkg::BLOCK_WORD_W)'(fbp_pkg::WORDS_PER_BLOCK - 1)) begin
                    state_d = fbp_pkg::FBP_IDLE;
                    done_d = 1'b1;
                end
            end
            default: state_d = fbp_pkg::FBP_IDLE;
        endcase
        // Refused reads also flag; the set wins over a clear
        if (data_req && !data_ok) begin
            viol_d = 1'b1;
            viol_addr_d = data_addr;
        end else if (dbg_req && !dbg_ok) begin
            viol_d = 1'b1;
            viol_addr_d = dbg_addr;
        end
        busy_d = (state_d == fbp_pkg::FBP_ERASE);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prot_q <= '0;
            state_q <= fbp_pkg::FBP_IDLE;
            erase_blk_q <= '0;
            erase_cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            viol_q <= 1'b0;
            viol_addr_q <= '0;
        end else if (clock_en) begin
            prot_q <= prot_d;
            state_q <= state_d;
            erase_blk_q <= erase_blk_d;
            erase_cnt_q <= erase_cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            viol_q <= viol_d;
            viol_addr_q <= viol_addr_d;
        end
    end

    // Array has no reset; contents start unknown like a fresh part
    always_ff @(posedge clock) begin
        if (clock_en && mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Read ports: one cycle, denied reads return zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fetch_valid_q <= 1'b0;
            data_valid_q <= 1'b0;
            dbg_valid_q <= 1'b0;
            fetch_data_q <= '0;
            data_rdata_q <= '0;
            dbg_rdata_q <= '0;
        end else if (clock_en) begin
            fetch_valid_q <= fetch_req && fetch_ok;
            data_valid_q <= data_req && data_ok;
            dbg_valid_q <= dbg_req && dbg_ok;
            fetch_data_q <= (fetch_req && fetch_ok) ? mem[fetch_addr] : '0;
            data_rdata_q <= (data_req && data_ok) ? mem[data_addr] : '0;
            dbg_rdata_q <= (dbg_req && dbg_ok) ? mem[dbg_addr] : '0;
        end
    end

    assign fetch_valid = fetch_valid_q;
    assign fetch_data = fetch_data_q;
    assign data_valid = data_valid_q;
    assign data_rdata = data_rdata_q;
    assign dbg_valid = dbg_valid_q;
    assign dbg_rdata = dbg_rdata_q;
    assign busy = busy_q;
    assign done = done_q;
    assign violation = viol_q;
    assign violation_addr = viol_addr_q;
endmodule

// File: rtl/fbp_pkg.sv
package fbp_pkg;
    localparam int FLASH_BYTES = 65536;
    localparam int BLOCK_BYTES = 1024;
    localparam int UNIT_BYTES = 2048;
    localparam int WORD_BYTES = 4;
    localparam int WORD_ADDR_W = 14;
    localparam int BLOCK_W = 6;
    localparam int UNIT_W = 5;
    localparam int NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
    localparam int BLOCK_WORD_W = 8;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

    typedef enum logic [1:0] {
        FBP_PROT_OPEN = 2'h0,
        FBP_PROT_READ_ONLY = 2'h1,
        FBP_PROT_EXEC_ONLY = 2'h2
    } fbp_prot_type;

    typedef enum logic [1:0] {
        FBP_IDLE = 2'h0,
        FBP_ERASE = 2'h1
    } fbp_state_type;
endpackage

// File: rtl/fbp_prot_check.sv
`timescale 1ns/100ps
module fbp_prot_check (
    // Unit settings, two bits each
    input wire logic [2*fbp_pkg::NUM_UNITS-1:0] prot_map,
    // Target block
    input wire logic [fbp_pkg::BLOCK_W-1:0] block_index,
    // Request kind
    input wire logic is_modify,
    input wire logic is_data_read,
    // Verdict
    output logic allowed
);
    logic [fbp_pkg::UNIT_W-1:0] unit;
    logic [1:0] setting;

    always_comb begin
        // Both blocks of a pair share one setting
        unit = block_index[fbp_pkg::BLOCK_W-1:1];
        setting = prot_map[2*unit +: 2];
        allowed = 1'b1;
        if (setting == fbp_pkg::FBP_PROT_READ_ONLY && is_modify) begin
            allowed = 1'b0;
        end
        if (setting == fbp_pkg::FBP_PROT_EXEC_ONLY && (is_modify || is_data_read)) begin
            allowed = 1'b0;
        end
    end
endmodule

// File: testbench/fbp_monitor.sv
`timescale 1ns/100ps
module fbp_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Requests
    input wire logic fetch_req,
    input wire logic data_req,
    input wire logic prog_req,
    input wire logic erase_req,
    input wire logic violation_clear,
    // Answers
    input wire logic fetch_valid,
    input wire logic data_valid,
    input wire logic [31:0] data_rdata,
    input wire logic busy,
    input wire logic done,
    input wire logic violation
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // 256 word writes, then done as busy drops
    sequence erase_run;
        ##255 (busy && !done) ##1 (done && !busy);
    endsequence
    fetch_serve_a: assert property (fetch_req && clock_en |=> fetch_valid)
        else $error("fetch not served");
    data_cause_a: assert property (data_valid && $past(clock_en) |-> $past(data_req))
        else $error("data answer without request");
    data_zero_a: assert property (!data_valid |-> data_rdata == 32'h0)
        else $error("refused read leaks data");
    data_answer_a: assert property (data_req && clock_en |=> data_valid || violation)
        else $error("data read neither served nor flagged");
    erase_start_a: assert property (erase_req && clock_en && !busy |=> busy || violation)
        else $error("erase neither started nor flagged");
    erase_len_a: assert property ($rose(busy) |-> erase_run)
        else $error("erase length wrong");
    viol_sticky_a: assert property (violation && !violation_clear |=> violation)
        else $error("violation dropped by itself");
    // A flag already standing would hide the answer, so only a clear flag is judged
    prog_answer_a: assert property (prog_req && clock_en && !erase_req && !busy && !violation
        |=> done ^ violation)
        else $error("program neither done nor flagged");
endmodule
bind fbp_flash_block_protection fbp_monitor fbp_monitor_inst (.*);

// File: testbench/fbp_fetch_model.sv
`timescale 1ns/100ps
module fbp_fetch_model (
    // Bench control
    input wire logic go,
    input wire logic [fbp_pkg::WORD_ADDR_W-1:0] addr,
    // Fetch side of the block
    output logic fetch_req,
    output logic [fbp_pkg::WORD_ADDR_W-1:0] fetch_addr
);
    logic [fbp_pkg::WORD_ADDR_W-1:0] last_q = '0;
    // Idle address scrambled so a stale match never passes
    always_comb fetch_addr = go ? addr : ~last_q;
    always_comb fetch_req = go;
    always @(negedge go) last_q = addr;
endmodule

// File: testbench/fbp_flash_block_protection_tb.sv
`timescale 1ns/100ps
module fbp_flash_block_protection_tb;
    typedef struct {logic [1:0] prot; int port; logic vld;} fbp_row_type;
    fbp_row_type rows [10] = '{'{2'h0, 0, 1'b1}, '{2'h0, 1, 1'b1}, '{2'h0, 2, 1'b1},
        '{2'h1, 0, 1'b1}, '{2'h1, 1, 1'b1}, '{2'h1, 2, 1'b1}, '{2'h2, 0, 1'b1},
        '{2'h2, 1, 1'b0}, '{2'h2, 2, 1'b0}, '{2'h3, 1, 1'b1}};
    logic clock = 0, reset_n = 0, fetch_go = 0, data_req = 0, dbg_req = 0, prog_req = 0;
    logic erase_req = 0, prot_we = 0, violation_clear = 0, v, clock_en = 1;
    logic [13:0] fetch_a = 0, data_addr = 0, dbg_addr = 0, prog_addr = 0, fetch_addr;
    logic [13:0] violation_addr;
    logic [31:0] prog_data = 0, fetch_data, data_rdata, dbg_rdata, d;
    logic [5:0] erase_block = 0;
    logic [4:0] prot_unit = 0;
    logic [1:0] prot_value = 0;
    logic fetch_req, fetch_valid, data_valid, dbg_valid, busy, done, violation;
    int err_total = 0, samples_checked = 0, cycles = 0, n;
    always #5 clock = ~clock;
    fbp_fetch_model fbp_fetch_model_inst (.go(fetch_go), .addr(fetch_a), .fetch_req,
        .fetch_addr);
    fbp_flash_block_protection fbp_flash_block_protection_inst (.clock, .reset_n,
        .clock_en, .fetch_req, .fetch_addr, .fetch_valid, .fetch_data, .data_req,
        .data_addr, .data_valid, .data_rdata, .dbg_req, .dbg_addr, .dbg_valid, .dbg_rdata,
        .prog_req, .prog_addr, .prog_data, .erase_req, .erase_block, .busy, .done, .prot_we,
        .prot_unit, .prot_value, .violation_clear, .violation, .violation_addr);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic rd(input int port, input logic [13:0] a);
        @(negedge clock);
        {fetch_go, data_req, dbg_req} = {port == 0, port == 1, port == 2};
        {fetch_a, data_addr, dbg_addr} = {a, a, a};
        @(negedge clock);
        {fetch_go, data_req, dbg_req} = 3'h0;
        v = port == 0 ? fetch_valid : port == 1 ? data_valid : dbg_valid;
        d = port == 0 ? fetch_data : port == 1 ? data_rdata : dbg_rdata;
    endtask
    task automatic prot(input logic [1:0] p);
        @(negedge clock);
        {prot_we, prot_value} = {1'b1, p};
        @(negedge clock);
        prot_we = 0;
    endtask
    task automatic erase(input logic [5:0] b);
        @(negedge clock);
        {erase_req, erase_block} = {1'b1, b};
        @(negedge clock);
        erase_req = 0;
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic prog(input logic [13:0] a, input logic [31:0] dt);
        @(negedge clock);
        {prog_req, prog_addr, prog_data} = {1'b1, a, dt};
        @(negedge clock);
        prog_req = 0;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(negedge clock);
        reset_n = 1;
        check({busy, done, violation, fetch_valid, data_valid, dbg_valid}, 0);
        $display("reset test ended");
        erase(1);
        check(n, 256);
        check(done, 1);
        prog(256, 32'h1234ABCD);
        check(done, 1);
        erase(0);
        rd(1, 255);
        check(d, 32'hFFFFFFFF);
        rd(1, 256);
        check(d, 32'h1234ABCD);
        $display("erase test ended");
        for (int i = 0; i < 10; i++) begin
            prot(rows[i].prot);
            rd(rows[i].port, 0);
            check(v, rows[i].vld);
            check(d, rows[i].vld ? 32'hFFFFFFFF : 32'h0);
        end
        $display("table test ended");
        @(negedge clock);
        violation_clear = 1;
        @(negedge clock);
        violation_clear = 0;
        check(violation, 0);
        prot(1);
        prog(0, 32'h0);
        check({done, violation, violation_addr}, 16'h4000);
        erase(1);
        check(n, 0);
        check(violation_addr, 256);
        rd(1, 256);
        check(d, 32'h1234ABCD);
        $display("refusal test ended");
        // Mid-run reset clears flags and reopens every unit, array kept
        @(negedge clock);
        reset_n = 0;
        repeat (2) @(negedge clock);
        reset_n = 1;
        check({busy, done, violation, fetch_valid, data_valid, dbg_valid, violation_addr}, 0);
        prog(257, 32'h0);
        check({done, violation}, 2'h2);
        $display("restart test ended");
        // Frozen clock enable must swallow a program request
        @(negedge clock);
        clock_en = 0;
        prog(256, 32'h0);
        clock_en = 1;
        check(done, 0);
        rd(1, 256);
        check(d, 32'h1234ABCD);
        rd(1, 257);
        check(d, 32'h0);
        $display("enable test ended");
        summarize();
    end
endmodule
